// ==== design/tfsr_defines.svh ====
// register offsets, field positions and reset values of the filter register bank
`ifndef TFSR_DEFINES_SVH
`define TFSR_DEFINES_SVH
`define TFSR_ADDR_W        9
`define TFSR_OFF_CFG_A     9'h000
`define TFSR_OFF_CFG_B     9'h001
`define TFSR_OFF_CHIP      9'h003
`define TFSR_OFF_PART_LO   9'h004
`define TFSR_OFF_PART_HI   9'h005
`define TFSR_OFF_END_IDX   9'h011
`define TFSR_OFF_BEGIN_IDX 9'h012
`define TFSR_OFF_DIR       9'h013
`define TFSR_OFF_PTR       9'h014
`define TFSR_OFF_DIRECT    9'h020
`define TFSR_OFF_TABLE     9'h100
`define TFSR_TABLE_SEL     8
`define TFSR_RST_CFG       8'h00
`define TFSR_RST_CFG_A     4'h0
`define TFSR_RST_OUT_CFG   4'h1
`define TFSR_RST_END_IDX   7'h7f
`define TFSR_RST_IDX       7'h00
`define TFSR_RST_CODE      8'h00
`define TFSR_CFGB_RW_MASK  8'he1
`define TFSR_BIT_SOFTRST   0
`define TFSR_BIT_STREAM    7
`define TFSR_HP_HI         7
`define TFSR_HP_LO         4
`define TFSR_LP_HI         3
`define TFSR_LP_LO         0
`endif

// ==== design/tfsr_pkg.sv ====
// types shared by the filter register bank
package tfsr_pkg;
  typedef logic [6:0] tfsr_idx_t;
  typedef logic [7:0] tfsr_byte_t;
  typedef enum logic {tfsr_mode_direct, tfsr_mode_table} tfsr_mode_e;
endpackage

// ==== design/tfsr_table_if.sv ====
// lookup table access bundle between the register bank and its table
`timescale 1ns/10ps
interface tfsr_table_if;
  logic                 wr_en;
  tfsr_pkg::tfsr_idx_t  wr_idx;
  tfsr_pkg::tfsr_byte_t wr_data;
  tfsr_pkg::tfsr_idx_t  rd_idx;
  tfsr_pkg::tfsr_byte_t rd_data;
  tfsr_pkg::tfsr_idx_t  seq_idx;
  tfsr_pkg::tfsr_byte_t seq_data;
  modport owner (output wr_en, wr_idx, wr_data, rd_idx, seq_idx, input rd_data, seq_data);
  modport store (input wr_en, wr_idx, wr_data, rd_idx, seq_idx, output rd_data, seq_data);
endinterface

// ==== design/tfsr_table.sv ====
// 128-entry filter state table with one write and two read ports
`timescale 1ns/10ps
`include "tfsr_defines.svh"
module tfsr_table #(
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_clr,
  // access
  tfsr_table_if.store tbl
);
  tfsr_pkg::tfsr_byte_t mem_q [DEPTH];

  assign tbl.rd_data  = mem_q[tbl.rd_idx];
  assign tbl.seq_data = mem_q[tbl.seq_idx];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= `TFSR_RST_CODE;
    end else if (soft_clr) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= `TFSR_RST_CODE;
    end else if (tbl.wr_en) begin
      mem_q[tbl.wr_idx] <= tbl.wr_data;
    end
  end
endmodule // tfsr_table

// ==== design/tfsr_stepper.sv ====
// fast-latch pointer sequencer
`timescale 1ns/10ps
`include "tfsr_defines.svh"
module tfsr_stepper (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                soft_clr,
  // controls
  input  wire logic                step,
  input  wire logic                restart,
  input  wire logic                dir_down,
  input  wire tfsr_pkg::tfsr_idx_t begin_idx,
  input  wire tfsr_pkg::tfsr_idx_t end_idx,
  // pointer
  output tfsr_pkg::tfsr_idx_t      ptr
);
  tfsr_pkg::tfsr_idx_t ptr_q;
  tfsr_pkg::tfsr_idx_t ptr_d;
  wire                 at_end = (ptr_q == end_idx);

  // wraps to start after the stop entry
  assign ptr_d = restart ? begin_idx :
                 at_end  ? begin_idx :
                 dir_down ? tfsr_pkg::tfsr_idx_t'(ptr_q - 7'h01) :
                            tfsr_pkg::tfsr_idx_t'(ptr_q + 7'h01);
  assign ptr = ptr_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ptr_q <= `TFSR_RST_IDX;
    else if (soft_clr) ptr_q <= `TFSR_RST_IDX;
    else if (step || restart) ptr_q <= ptr_d;
  end
endmodule // tfsr_stepper

// ==== design/tfsr_regs.sv ====
// register bank of the tunable filter serial control port
`timescale 1ns/10ps
`include "tfsr_defines.svh"
module tfsr_regs #(
  parameter logic [7:0]  CHIP_CATEGORY = 8'h5a, // arbitrary value
  parameter logic [15:0] PART_CODE     = 16'ha5c3 // arbitrary value
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register access from the serial port engine
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [`TFSR_ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  output logic [7:0]                      reg_rdata,
  output logic                            reg_rvalid,
  // serial port configuration
  output logic                            lsb_first,
  output logic                            big_endian,
  output logic                            sdo_enable,
  output logic                            single_instruction,
  // filter control
  input  wire logic                       mode_table,
  input  wire logic                       latch_step,
  output logic [3:0]                      highpass_code,
  output logic [3:0]                      lowpass_code
);
  // ********************************
  // storage
  // ********************************
  logic [3:0]           cfg_a_q;
  logic [7:0]           cfg_b_q;
  tfsr_pkg::tfsr_idx_t  end_idx_q;
  tfsr_pkg::tfsr_idx_t  begin_idx_q;
  logic                 dir_q;
  tfsr_pkg::tfsr_byte_t direct_q;
  logic [7:0]           rdata_q;
  logic                 rvalid_q;
  logic [7:0]           filt_q;
  logic [3:0]           out_cfg_q;
  logic                 mode_q;
  tfsr_pkg::tfsr_idx_t  ptr;
  tfsr_table_if         tbl ();

  // ********************************
  // decode
  // ********************************
  function automatic logic hit(input logic [`TFSR_ADDR_W-1:0] a, input logic [`TFSR_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // a one in either mirrored copy sets the bit; both low clears it
  function automatic logic [3:0] fold_cfg(input logic [7:0] d);
    fold_cfg = d[3:0] | {d[4], d[5], d[6], d[7]};
  endfunction

  wire       wr_cfg_a   = reg_wr && hit(reg_addr, `TFSR_OFF_CFG_A);
  wire       wr_cfg_b   = reg_wr && hit(reg_addr, `TFSR_OFF_CFG_B);
  wire       wr_end     = reg_wr && hit(reg_addr, `TFSR_OFF_END_IDX);
  wire       wr_begin   = reg_wr && hit(reg_addr, `TFSR_OFF_BEGIN_IDX);
  wire       wr_dir     = reg_wr && hit(reg_addr, `TFSR_OFF_DIR);
  wire       wr_direct  = reg_wr && hit(reg_addr, `TFSR_OFF_DIRECT);
  wire       table_sel  = reg_addr[`TFSR_TABLE_SEL];
  wire [3:0] cfg_a_new  = fold_cfg(reg_wdata);
  // a write with bits 0 and 7 both at zero resets the bank for one cycle
  wire       soft_clr   = wr_cfg_a && !cfg_a_new[`TFSR_BIT_SOFTRST];
  wire       mode_edge  = mode_table && !mode_q;

  assign tbl.wr_en   = reg_wr && table_sel && !soft_clr;
  assign tbl.wr_idx  = reg_addr[6:0];
  assign tbl.wr_data = reg_wdata;
  assign tbl.rd_idx  = reg_addr[6:0];
  assign tbl.seq_idx = ptr;

  // ********************************
  // read mux
  // ********************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (table_sel) rd_mux = tbl.rd_data;
    else begin
      unique case (reg_addr)
        `TFSR_OFF_CFG_A:     rd_mux = {cfg_a_q[0], cfg_a_q[1], cfg_a_q[2], cfg_a_q[3], cfg_a_q};
        `TFSR_OFF_CFG_B:     rd_mux = cfg_b_q;
        `TFSR_OFF_CHIP:      rd_mux = CHIP_CATEGORY;
        `TFSR_OFF_PART_LO:   rd_mux = PART_CODE[7:0];
        `TFSR_OFF_PART_HI:   rd_mux = PART_CODE[15:8];
        `TFSR_OFF_END_IDX:   rd_mux = {1'b0, end_idx_q};
        `TFSR_OFF_BEGIN_IDX: rd_mux = {1'b0, begin_idx_q};
        `TFSR_OFF_DIR:       rd_mux = {7'h00, dir_q};
        `TFSR_OFF_PTR:       rd_mux = {1'b0, ptr};
        `TFSR_OFF_DIRECT:    rd_mux = direct_q;
        default:             rd_mux = 8'h00;
      endcase
    end
  end

  // ********************************
  // filter source selection
  // ********************************
  wire [7:0] filt_d = mode_table ? (latch_step ? tbl.seq_data : filt_q) : direct_q;

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_a_q     <= `TFSR_RST_CFG_A;
      cfg_b_q     <= `TFSR_RST_CFG;
      end_idx_q   <= `TFSR_RST_END_IDX;
      begin_idx_q <= `TFSR_RST_IDX;
      dir_q       <= 1'b0;
      direct_q    <= `TFSR_RST_CODE;
    end else if (soft_clr) begin
      cfg_a_q     <= `TFSR_RST_CFG_A;
      cfg_b_q     <= `TFSR_RST_CFG;
      end_idx_q   <= `TFSR_RST_END_IDX;
      begin_idx_q <= `TFSR_RST_IDX;
      dir_q       <= 1'b0;
      direct_q    <= `TFSR_RST_CODE;
    end else begin
      if (wr_cfg_a)  cfg_a_q     <= cfg_a_new;
      if (wr_cfg_b)  cfg_b_q     <= reg_wdata & `TFSR_CFGB_RW_MASK;
      if (wr_end)    end_idx_q   <= reg_wdata[6:0];
      if (wr_begin)  begin_idx_q <= reg_wdata[6:0];
      if (wr_dir)    dir_q       <= reg_wdata[0];
      if (wr_direct) direct_q    <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
      filt_q    <= `TFSR_RST_CODE;
      out_cfg_q <= `TFSR_RST_OUT_CFG;
      mode_q    <= 1'b0;
    end else begin
      rdata_q   <= reg_rd ? rd_mux : rdata_q;
      rvalid_q  <= reg_rd;
      filt_q    <= filt_d;
      out_cfg_q <= {cfg_b_q[`TFSR_BIT_STREAM], cfg_a_q[3:2], !cfg_a_q[1]};
      mode_q    <= mode_table;
    end
  end

  assign reg_rdata          = rdata_q;
  assign reg_rvalid         = rvalid_q;
  assign single_instruction = out_cfg_q[3];
  assign sdo_enable         = out_cfg_q[2];
  assign big_endian         = out_cfg_q[1];
  assign lsb_first          = out_cfg_q[0];
  assign highpass_code      = filt_q[`TFSR_HP_HI:`TFSR_HP_LO];
  assign lowpass_code       = filt_q[`TFSR_LP_HI:`TFSR_LP_LO];

  // ********************************
  // children
  // ********************************
  tfsr_table #(.DEPTH(128)) u_table (
    .clk      (clk),
    .rst      (rst),
    .soft_clr (soft_clr),
    .tbl      (tbl.store)
  );

  tfsr_stepper u_step (
    .clk       (clk),
    .rst       (rst),
    .soft_clr  (soft_clr),
    .step      (latch_step && mode_table),
    .restart   (mode_edge),
    .dir_down  (dir_q),
    .begin_idx (begin_idx_q),
    .end_idx   (end_idx_q),
    .ptr       (ptr)
  );
endmodule // tfsr_regs

// ==== sim/tfsr_host.sv ====
// serial host model issuing byte accesses to the register bank
`timescale 1ns/10ps
module tfsr_host (
  // clock
  input  wire logic       clk,
  // byte access
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [8:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h1ff;
    reg_wdata = 8'h00;
  end
  // one strobed byte, then released lines show inverted values
  task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clk);
    #1 q = reg_rdata;
  endtask
endmodule // tfsr_host

// ==== sim/tfsr_regs_checker.sv ====
// port assertions for the filter register bank
`timescale 1ns/10ps
`include "tfsr_defines.svh"
module tfsr_regs_checker #(
  parameter logic [7:0]  CHIP_CATEGORY = 8'h5a, // arbitrary value
  parameter logic [15:0] PART_CODE     = 16'ha5c3 // arbitrary value
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // register access
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [`TFSR_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    reg_rvalid,
  // outputs and filter control
  input wire logic                    lsb_first,
  input wire logic                    big_endian,
  input wire logic                    sdo_enable,
  input wire logic                    single_instruction,
  input wire logic                    mode_table,
  input wire logic                    latch_step,
  input wire logic [3:0]              highpass_code,
  input wire logic [3:0]              lowpass_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cfg_mirror_a: assert property (
    reg_rvalid && $past(reg_addr) == 9'h000 |-> reg_rdata[7:4] == {reg_rdata[0], reg_rdata[1], reg_rdata[2], reg_rdata[3]})
    else $error("config mirror broken");
  cfg_levels_a: assert property (
    reg_rvalid && $past(reg_addr) == 9'h000 |-> {lsb_first, big_endian, sdo_enable} == {!reg_rdata[1], reg_rdata[2], reg_rdata[3]})
    else $error("config outputs differ");
  read_valid_a: assert property (
    reg_rvalid == $past(reg_rd))
    else $error("read valid pulse wrong");
  read_hold_a: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  stream_ctl_a: assert property (
    reg_rvalid && $past(reg_addr) == 9'h001 |-> single_instruction == reg_rdata[7] && reg_rdata[4:1] == 4'h0)
    else $error("stream control wrong");
  index_top_a: assert property (
    reg_rvalid && $past(reg_addr) inside {9'h011, 9'h012, 9'h014} |-> !reg_rdata[7])
    else $error("index bit 7 set");
  dir_field_a: assert property (
    reg_rvalid && $past(reg_addr) == 9'h013 |-> reg_rdata[7:1] == 7'h00)
    else $error("direction upper bits set");
  chip_id_a: assert property (
    reg_rvalid && $past(reg_addr) == 9'h003 |-> reg_rdata == CHIP_CATEGORY)
    else $error("chip category wrong");
  part_id_a: assert property (
    reg_rvalid && $past(reg_addr) inside {9'h004, 9'h005} |-> reg_rdata == PART_CODE[$past(reg_addr[0]) * 8 +: 8])
    else $error("part code wrong");
  direct_apply_a: assert property (
    reg_wr && reg_addr == 9'h020 && !mode_table ##1 !reg_wr && !mode_table
      |=> {highpass_code, lowpass_code} == $past(reg_wdata, 2))
    else $error("direct codes not applied");
  step_hold_a: assert property (
    mode_table && $past(mode_table) && !$past(latch_step) |-> $stable({highpass_code, lowpass_code}))
    else $error("codes moved without step");
endmodule // tfsr_regs_checker
bind tfsr_regs tfsr_regs_checker #(.CHIP_CATEGORY(CHIP_CATEGORY), .PART_CODE(PART_CODE)) tfsr_regs_checker_inst (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .lsb_first(lsb_first), .big_endian(big_endian), .sdo_enable(sdo_enable),
  .single_instruction(single_instruction), .mode_table(mode_table), .latch_step(latch_step),
  .highpass_code(highpass_code), .lowpass_code(lowpass_code));

// ==== sim/tfsr_regs_test.sv ====
// self-checking bench for the filter register bank
`timescale 1ns/10ps
module tfsr_regs_test;
  logic       clk, rst, reg_wr, reg_rd, reg_rvalid, mode_table, latch_step;
  logic       lsb_first, big_endian, sdo_enable, single_instruction;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] highpass_code, lowpass_code;
  int         err_count = 0;
  int         checks = 0;
  logic [8:0] ra [13] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h011, 9'h012, 9'h013, 9'h014, 9'h020,
                          9'h100, 9'h17f};
  logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h00, 8'h5a, 8'hc3, 8'ha5, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv [13] = '{8'h00, 8'he1, 8'h00, 8'h5a, 8'hc3, 8'ha5, 8'h7f, 8'h7f, 8'h01, 8'h00, 8'hff, 8'hff, 8'hff};
  tfsr_regs tfsr_regs_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lsb_first(lsb_first),
    .big_endian(big_endian), .sdo_enable(sdo_enable), .single_instruction(single_instruction),
    .mode_table(mode_table), .latch_step(latch_step), .highpass_code(highpass_code), .lowpass_code(lowpass_code));
  tfsr_host tfsr_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    tfsr_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] q;
    tfsr_host_inst.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic flg(input logic [7:0] e);
    chk("flags", e, {4'h0, lsb_first, big_endian, sdo_enable, single_instruction});
  endtask
  task automatic sweep(input logic [7:0] ev [13]);
    for (int i = 0; i < 13; i++) rchk(ra[i], ev[i]);
  endtask
  // program a latch run, then take four steps and read the pointer
  task automatic seq(input logic [7:0] b, input logic [7:0] e, input logic [7:0] d, input logic [31:0] x);
    @(posedge clk) mode_table <= 1'b0;
    wr(9'h012, b);
    wr(9'h011, e);
    wr(9'h013, d);
    @(posedge clk) mode_table <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) latch_step <= 1'b1;
      @(posedge clk) latch_step <= 1'b0;
      #1 chk("codes", x[31-8*i -: 8], {highpass_code, lowpass_code});
    end
    rchk(9'h014, 8'h06);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    mode_table = 1'b0;
    latch_step = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    flg(8'h08);
    sweep(rv);
    for (int i = 1; i < 13; i++) wr(ra[i], 8'hff);
    sweep(wv);
    flg(8'h09);
    $display("test access done");
    wr(9'h000, 8'h00);
    sweep(rv);
    flg(8'h08);
    $display("test soft reset done");
    wr(9'h000, 8'h21);
    rchk(9'h000, 8'ha5);
    flg(8'h0c);
    wr(9'h000, 8'h0b);
    rchk(9'h000, 8'hdb);
    flg(8'h02);
    $display("test config done");
    wr(9'h020, 8'h3c);
    @(posedge clk);
    #1 chk("direct", 8'h3c, {highpass_code, lowpass_code});
    $display("test direct done");
    wr(9'h105, 8'h15);
    wr(9'h106, 8'h26);
    wr(9'h107, 8'h37);
    seq(8'h05, 8'h07, 8'h00, 32'h15263715);
    seq(8'h07, 8'h05, 8'h01, 32'h37261537);
    $display("test latch done");
    final_report();
  end
endmodule // tfsr_regs_test
